/* src/eelc_top.sv */
// Edge event line controller: pin routing, edge detection, pending, masks, requests.
// Assumes all inputs are synchronous to ref_clk_i and the register port follows the plain strobe protocol.
`timescale 1ns/1ps
`default_nettype none
`include "eelc_defs.svh"

module eelc_top
    import eelc_pkg::*;
#(
    parameter int NUM_PINS = `EELC_NUM_PINS
) (
    input  wire logic                ref_clk_i,
    input  wire logic                reset_i,
    input  wire eelc_bus_req_t       bus_req_i,
    output logic [31:0]              rdata_o,
    input  wire logic [NUM_PINS-1:0] gpio_i,
    input  wire logic                supply_mon_i,
    input  wire logic                alarm_i,
    input  wire logic                bus_wake_i,
    output eelc_lines_t              line_irq_o,
    output eelc_lines_t              line_evt_o,
    output logic                     irq_o,
    output logic                     wake_o
);

    eelc_lines_t rise;
    eelc_lines_t fall;
    eelc_lines_t imask;
    eelc_lines_t emask;
    eelc_lines_t pend;
    eelc_sel_t   sel [`EELC_NUM_EXT];

    eelc_lines_t next_rise;
    eelc_lines_t next_fall;
    eelc_lines_t next_imask;
    eelc_lines_t next_emask;
    eelc_lines_t next_pend;
    eelc_sel_t   next_sel [`EELC_NUM_EXT];
    logic [31:0] next_rdata;
    eelc_lines_t next_line_irq;
    eelc_lines_t next_line_evt;
    logic        next_irq;
    logic        next_wake;

    eelc_lines_t line_now;
    eelc_lines_t hit;
    eelc_lines_t clr_vec;
    eelc_lines_t hit_em;

    // Selectors beyond the last pin read as a quiet line rather than wrapping.
    function automatic logic pin_pick(input logic [NUM_PINS-1:0] pins, input eelc_sel_t s);
        logic bit_v;
        bit_v = 1'b0;
        if (int'(s) < NUM_PINS) begin
            bit_v = pins[s];
        end
        return bit_v;
    endfunction : pin_pick

    function automatic logic sel_hit(input logic [`EELC_ADDR_W-1:0] a, input int idx);
        return (a[7:6] == 2'b01) && (a[5:2] == idx[3:0]) && (a[1:0] == 2'b00);
    endfunction : sel_hit

    // Pin routing for the 16 external lines; the supply, alarm and bus wake lines have fixed sources.
    // Moving a selector can look like an edge on the newly chosen pin.
    // Line source map.
    always_comb begin
        line_now = '0;
        for (int k = 0; k < `EELC_NUM_EXT; k++) begin
            line_now[k] = pin_pick(gpio_i, sel[k]);
        end
        line_now[`EELC_LINE_SUPPLY]  = supply_mon_i;
        line_now[`EELC_LINE_ALARM]   = alarm_i;
        line_now[`EELC_LINE_BUSWAKE] = bus_wake_i;
    end

    // Sampled at core rate.
    // The detectors run on ref_clk_i, the same clock as the register port, so a pulse of one clock cycle is seen.
    genvar g;
    generate
        for (g = 0; g < `EELC_NUM_LINES; g++) begin : g_cell
            eelc_edge_cell u_cell (
                .ref_clk_i (ref_clk_i),
                .reset_i   (reset_i),
                .line_i    (line_now[g]),
                .rise_en_i (rise[g]),
                .fall_en_i (fall[g]),
                .hit_o     (hit[g])
            );
        end
    endgenerate

    assign clr_vec = (bus_req_i.wr && bus_req_i.addr == `EELC_OFF_PEND)
                     ? bus_req_i.wdata[`EELC_NUM_LINES-1:0] : '0;
    assign hit_em  = hit & emask;

    always_comb begin
        next_rise  = rise;
        next_fall  = fall;
        next_imask = imask;
        next_emask = emask;
        next_sel   = sel;
        next_rdata = 32'h0000_0000;
        if (bus_req_i.wr) begin
            case (bus_req_i.addr)
                `EELC_OFF_RISE: begin
                    next_rise = bus_req_i.wdata[`EELC_NUM_LINES-1:0];
                end
                `EELC_OFF_FALL: begin
                    next_fall = bus_req_i.wdata[`EELC_NUM_LINES-1:0];
                end
                `EELC_OFF_IRQ_MASK: begin
                    next_imask = bus_req_i.wdata[`EELC_NUM_LINES-1:0];
                end
                `EELC_OFF_EVT_MASK: begin
                    next_emask = bus_req_i.wdata[`EELC_NUM_LINES-1:0];
                end
                default: begin
                    for (int k = 0; k < `EELC_NUM_EXT; k++) begin
                        if (sel_hit(bus_req_i.addr, k)) begin
                            next_sel[k] = bus_req_i.wdata[`EELC_SEL_W-1:0];
                        end
                    end
                end
            endcase
        end
        if (bus_req_i.rd) begin
            case (bus_req_i.addr)
                `EELC_OFF_RISE:     next_rdata = {13'h0000, rise};
                `EELC_OFF_FALL:     next_rdata = {13'h0000, fall};
                `EELC_OFF_IRQ_MASK: next_rdata = {13'h0000, imask};
                `EELC_OFF_EVT_MASK: next_rdata = {13'h0000, emask};
                `EELC_OFF_PEND:     next_rdata = {13'h0000, pend};
                default: begin
                    for (int k = 0; k < `EELC_NUM_EXT; k++) begin
                        if (sel_hit(bus_req_i.addr, k)) begin
                            next_rdata = {25'h0000000, sel[k]};
                        end
                    end
                end
            endcase
        end
        // Write one clears.
        // A new edge in the clearing cycle keeps its bit: set wins over clear.
        next_pend = (pend & ~clr_vec) | hit;
        next_line_irq = next_pend & next_imask;
        next_line_evt = hit & emask;
        next_irq      = |next_line_irq;
        // Stop wakeup request.
        // Raised by a fresh enabled trigger or by any unmasked pending line.
        next_wake     = (|(hit & (imask | emask))) | next_irq;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rise       <= `EELC_RST_LINES;
            fall       <= `EELC_RST_LINES;
            imask      <= `EELC_RST_LINES;
            emask      <= `EELC_RST_LINES;
            pend       <= `EELC_RST_LINES;
            for (int k = 0; k < `EELC_NUM_EXT; k++) begin
                sel[k] <= `EELC_RST_SEL;
            end
            rdata_o    <= 32'h0000_0000;
            line_irq_o <= `EELC_RST_LINES;
            line_evt_o <= `EELC_RST_LINES;
            irq_o      <= 1'b0;
            wake_o     <= 1'b0;
        end else begin
            rise       <= next_rise;
            fall       <= next_fall;
            imask      <= next_imask;
            emask      <= next_emask;
            pend       <= next_pend;
            sel        <= next_sel;
            rdata_o    <= next_rdata;
            line_irq_o <= next_line_irq;
            line_evt_o <= next_line_evt;
            irq_o      <= next_irq;
            wake_o     <= next_wake;
        end
    end

    a_pend_catch_hit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (hit != '0) |=> ((pend & $past(hit)) == $past(hit)))
        else $error("Detected edge did not set its pending bit.");

    a_pend_stays_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clr_vec == '0) |=> ((pend & $past(pend)) == $past(pend)))
        else $error("Pending bit dropped without a clearing write.");

    a_clear_by_one: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ((clr_vec != '0) && ((hit & clr_vec) == '0)) |=> ((pend & $past(clr_vec)) == '0))
        else $error("Writing one did not clear the pending bit.");

    a_edge_select: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        hit == ((line_now & ~$past(line_now) & rise) | (~line_now & $past(line_now) & fall)))
        else $error("Edge hit disagrees with chosen trigger edges.");

    a_mask_isolate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ((line_irq_o & ~imask) == '0) && (line_irq_o == (pend & imask)))
        else $error("Line request does not follow pending and its mask.");

    a_event_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        line_evt_o == $past(hit_em))
        else $error("Event request is not the masked edge one cycle later.");

    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        irq_o == (|(pend & imask)))
        else $error("Interrupt output disagrees with unmasked pending bits.");

    a_wake_raise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ((hit & (imask | emask)) != '0) |=> wake_o)
        else $error("Enabled trigger did not raise the wakeup.");

    a_pend_readback: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (bus_req_i.rd && bus_req_i.addr == `EELC_OFF_PEND) |=> (rdata_o == {13'h0000, $past(pend)}))
        else $error("Pending read did not return the pending register.");

    a_pin_route: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (int'(sel[0]) < NUM_PINS) |-> (line_now[0] == gpio_i[sel[0]]))
        else $error("Line zero does not follow its selected pin.");

endmodule : eelc_top

`default_nettype wire

/* src/eelc_defs.svh */
// Constants of the edge event line controller: offsets, field widths, reset values.
// Included by the package and by the top design file; holds definitions only.
`ifndef EELC_DEFS_SVH
`define EELC_DEFS_SVH

`define EELC_NUM_LINES      19
`define EELC_NUM_EXT        16
`define EELC_NUM_PINS       80
`define EELC_SEL_W          7
`define EELC_LINE_SUPPLY    16
`define EELC_LINE_ALARM     17
`define EELC_LINE_BUSWAKE   18

`define EELC_ADDR_W         8
`define EELC_OFF_RISE       8'h00
`define EELC_OFF_FALL       8'h04
`define EELC_OFF_IRQ_MASK   8'h08
`define EELC_OFF_EVT_MASK   8'h0c
`define EELC_OFF_PEND       8'h10
`define EELC_OFF_SEL_BASE   8'h40

`define EELC_RST_LINES      19'h00000
`define EELC_RST_SEL        7'h00

`endif

/* src/eelc_pkg.sv */
// Types shared by the edge event line controller files.
// Assumes the constants header is on the include path.
`default_nettype none
`include "eelc_defs.svh"

package eelc_pkg;

    typedef logic [`EELC_NUM_LINES-1:0] eelc_lines_t;
    typedef logic [`EELC_SEL_W-1:0]     eelc_sel_t;

    typedef struct packed {
        logic [`EELC_ADDR_W-1:0] addr;
        logic [31:0]             wdata;
        logic                    wr;
        logic                    rd;
    } eelc_bus_req_t;

endpackage : eelc_pkg

`default_nettype wire

/* src/eelc_edge_cell.sv */
// One edge detector: remembers the last sample and flags the chosen edges.
// Assumes the line is synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module eelc_edge_cell (
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic line_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    output logic      hit_o
);

    logic last;
    logic next_last;

    always_comb begin
        next_last = line_i;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            last <= 1'b0;
        end else begin
            last <= next_last;
        end
    end

    // Edge choice per line.
    // Both enables set gives either edge; the hit is combinational so the pending flop takes it the same edge.
    assign hit_o = (rise_en_i & line_i & ~last) | (fall_en_i & ~line_i & last);

endmodule : eelc_edge_cell

`default_nettype wire

/* tb/eelc_line_model.sv */
// Model of the pins and internal sources that feed the edge event line controller.
// Assumes the bench calls set_line and that lines stay synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module eelc_line_model (
    input  wire logic   ref_clk_i,
    output logic [79:0] gpio_o,
    output logic        supply_mon_o,
    output logic        alarm_o,
    output logic        bus_wake_o
);
    logic [82:0] lvl = '0;

    assign gpio_o       = lvl[79:0];
    assign supply_mon_o = lvl[80];
    assign alarm_o      = lvl[81];
    assign bus_wake_o   = lvl[82];

    // Levels move just after a rising edge, so every level is held a whole clock.
    task automatic set_line(input int idx, input logic v);
        @(posedge ref_clk_i);
        lvl[idx] <= v;
    endtask : set_line
endmodule : eelc_line_model
`default_nettype wire

/* tb/edge_event_line_controller_tb_top.sv */
// Self-checking bench for the edge event line controller.
// Assumes the pin model above and the plain strobe register port.
`timescale 1ns/1ps
`default_nettype none

module edge_event_line_controller_tb_top import eelc_pkg::*; ;
    logic          ref_clk_i  = 1'b0;
    logic          reset_i    = 1'b1;
    eelc_bus_req_t req        = '0;
    logic [31:0]   rdata_o;
    logic [79:0]   gpio;
    logic          supply;
    logic          alarm;
    logic          bus_wake;
    eelc_lines_t   line_irq_o;
    eelc_lines_t   line_evt_o;
    logic          irq_o;
    logic          wake_o;
    int            n_fail     = 0;
    int            num_checks = 0;
    logic [7:0]    offs [8]   = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h78, 8'h24};

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    eelc_line_model model_u (.ref_clk_i(ref_clk_i), .gpio_o(gpio), .supply_mon_o(supply),
                             .alarm_o(alarm), .bus_wake_o(bus_wake));

    eelc_top dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_req_i(req), .rdata_o(rdata_o),
                    .gpio_i(gpio), .supply_mon_i(supply), .alarm_i(alarm), .bus_wake_i(bus_wake),
                    .line_irq_o(line_irq_o), .line_evt_o(line_evt_o), .irq_o(irq_o), .wake_o(wake_o));

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        #1;
        chk(rdata_o, exp, msg);
    endtask : rd

    // Outputs packed as irq, wake, per-line interrupt requests.
    task automatic chk_irq(input logic [1:0] iw, input logic [18:0] lines, input string msg);
        chk({11'h0, irq_o, wake_o, line_irq_o}, {11'h0, iw, lines}, msg);
    endtask : chk_irq

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // A hang in any sequence counts as a mismatch.
    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        wr(8'h24, 32'hffff_ffff);
        foreach (offs[i]) rd(offs[i], 32'h0, "reset or unmapped");
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h0007_ffff, "nineteen lines");
        wr(8'h00, 32'h0000_0008);
        wr(8'h4c, 32'h0000_00c6);
        rd(8'h4c, 32'h0000_0046, "selector");
        wr(8'h08, 32'h0000_0008);
        model_u.set_line(71, 1'b1);
        tick();
        chk_irq(2'b00, 19'h0, "unselected pin");
        model_u.set_line(70, 1'b1);
        tick();
        chk_irq(2'b11, 19'h8, "routed rise");
        rd(8'h10, 32'h8, "pending");
        wr(8'h10, 32'h8);
        tick();
        chk_irq(2'b00, 19'h0, "cleared");
        model_u.set_line(70, 1'b0);
        model_u.set_line(70, 1'b1);
        model_u.set_line(70, 1'b0);
        tick();
        rd(8'h10, 32'h8, "short pulse");
        wr(8'h10, 32'h8);
        // A selector past the last pin must give a quiet line.
        wr(8'h4c, 32'h0000_0050);
        model_u.set_line(70, 1'b1);
        tick();
        rd(8'h10, 32'h0, "quiet selector");
        wr(8'h04, 32'h0002_0000);
        wr(8'h0c, 32'h0002_0000);
        model_u.set_line(81, 1'b1);
        tick();
        rd(8'h10, 32'h0, "rise ignored");
        model_u.set_line(81, 1'b0);
        tick();
        chk({11'h0, irq_o, wake_o, line_evt_o}, 32'h000a_0000, "fall event");
        tick();
        chk({11'h0, irq_o, wake_o, line_evt_o}, 32'h0, "event one cycle");
        rd(8'h10, 32'h0002_0000, "alarm pending");
        wr(8'h10, 32'h0002_0000);
        wr(8'h00, 32'h0001_0000);
        wr(8'h04, 32'h0001_0000);
        for (int v = 1; v >= 0; v--) begin
            model_u.set_line(80, v[0]);
            tick();
            rd(8'h10, 32'h0001_0000, "both edges");
            wr(8'h10, 32'h0001_0000);
        end
        wr(8'h00, 32'h0004_0000);
        model_u.set_line(82, 1'b1);
        tick();
        chk_irq(2'b00, 19'h0, "masked line");
        rd(8'h10, 32'h0004_0000, "masked pends");
        wr(8'h08, 32'h0004_0008);
        tick();
        chk_irq(2'b11, 19'h4_0000, "unmasked wake");
        wr(8'h10, 32'h0004_0000);
        tick();
        chk_irq(2'b00, 19'h0, "final clear");
        test_done();
    end
endmodule : edge_event_line_controller_tb_top
`default_nettype wire
